// file: include/wrs_pkg.sv
/*
  constants and state types shared by the watchdog and reset supervisor.
  assumes a 10 MHz system clock and a 1 us internal time base.
*/
package wrs_pkg;

  // system clock
  localparam int unsigned CLK_PERIOD_NS   = 100;          // 10 MHz
  // time base: one tick per microsecond
  localparam int unsigned TICK_NS         = 1000;
  localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // durations in microsecond ticks
  localparam int unsigned STARTUP_S       = 54;           // first-kick grace
  localparam int unsigned STARTUP_US      = STARTUP_S * 1000000;
  localparam int unsigned WDT_MS          = 1000;         // plain default timeout
  localparam int unsigned WDT_US          = WDT_MS * 1000;
  localparam int unsigned RST_INT_MS      = 140;          // internal reset timeout
  localparam int unsigned RST_INT_US      = RST_INT_MS * 1000;

  // capacitor timeout: 2.06 Mohm times capacitance, 2.06 Mohm * 1 nF = 2060 us
  localparam int unsigned SRT_MOHM_X100   = 206;          // 2.06 scaled by 100
  localparam int unsigned SRT_US_PER_NF   = SRT_MOHM_X100 * 1000 / 100;

  // widths
  localparam int unsigned CNT_W           = 32;           // tick counters
  localparam int unsigned CAP_W           = 16;           // capacitance in nF
  localparam int unsigned SYNC_W          = 9;            // synchronised pins

  // bit positions inside the synchronised pin vector
  localparam int unsigned PIN_KICK        = 0;
  localparam int unsigned PIN_OPEN        = 1;
  localparam int unsigned PIN_MR_N        = 2;
  localparam int unsigned PIN_MARGIN_N    = 3;
  localparam int unsigned PIN_SRT_VCC     = 4;
  localparam int unsigned PIN_RAIL5       = 5;             // rails 5..8 at 5..8

  // supervisor reset output states
  typedef enum logic [1:0] {
    WRS_RST_HOLD    = 2'b00,                              // cause present
    WRS_RST_TIMEOUT = 2'b01,                              // stretching
    WRS_RST_RUN     = 2'b10                               // released
  } wrs_rst_state_type;

  // watchdog states
  typedef enum logic [1:0] {
    WRS_WD_OFF      = 2'b00,                              // input left open
    WRS_WD_STARTUP  = 2'b01,                              // waiting first kick
    WRS_WD_RUN      = 2'b10                               // normal timeout
  } wrs_wd_state_type;

endpackage : wrs_pkg

// file: rtl/wrs_sync2.sv
/*
  two flip-flop synchroniser for a vector of independent pin levels.
  assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module wrs_sync2 #(
  parameter int unsigned W     = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;   // first stage, read only by second stage

  // two stages, synchronous reset to the idle level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : wrs_sync2

// file: rtl/wrs_tick_div.sv
/*
  clock divider giving a one-cycle enable pulse every CYCLES clocks.
  assumes CYCLES is at least one.
*/
`timescale 1ns/1ps
module wrs_tick_div #(
  parameter int unsigned CYCLES = 10
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // enable pulse
  output logic      tick
);

  localparam int unsigned DW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [DW-1:0] LAST = DW'(CYCLES - 1);

  logic [DW-1:0] div_reg;   // cycle count inside one period

  // free-running count, pulse on the last cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_reg == LAST);
      div_reg <= (div_reg == LAST) ? '0 : div_reg + 1'b1;
    end
  end

endmodule : wrs_tick_div

// file: rtl/wrs_supervisor.sv
/*
  watchdog and reset supervisor: kick-edge watchdog with startup grace and
  open-pin disable, manual reset with timeout stretch, per-rail fault
  outputs for rails five to eight, margin disable of all outputs.
  assumes rail comparator results arrive as digital levels (1 = above
  threshold) and that open-drain pad wiring is done outside.
*/
`timescale 1ns/1ps
// Behaviour
// R1: steady kick past timeout asserts reset, clears
// R2: any kick edge clears watchdog timer
// R3: asserted reset output clears watchdog timer
// R4: startup grace before first kick after reset
// R5: open kick pin disables watchdog entirely
// R6: rail fault low while rail below threshold
// R7: manual reset low holds reset asserted
// R8: reset held one timeout after manual release
// R9: capacitor timeout scales with programmed capacitance
// R10: supply-tied timeout pin selects internal timeout
// R11: any low rail asserts reset, then stretched
// R12: margin low releases every output
// R13: long durations counted from divided tick
// R14: pin inputs synchronised before any use
module wrs_supervisor
  import wrs_pkg::*;
#(
  parameter int unsigned STARTUP_TICKS = STARTUP_US,   // startup grace, us
  parameter int unsigned WDT_TICKS     = WDT_US,       // watchdog timeout, us
  parameter int unsigned RST_INT_TICKS = RST_INT_US    // internal reset timeout, us
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // watchdog pins
  input  wire logic             watchdog_kick_in,
  input  wire logic             kick_open,
  // manual reset and margin
  input  wire logic             manual_reset_n,
  input  wire logic             margin_n,
  // reset timeout selection
  input  wire logic             timeout_set_pin,
  input  wire logic [CAP_W-1:0] srt_cap_nf,
  // rail comparator levels
  input  wire logic             rail5_sense,
  input  wire logic             rail6_sense,
  input  wire logic             rail7_sense,
  input  wire logic             rail8_sense,
  // reset open-drain pin
  input  wire logic             reset_pin_in,
  output logic                  reset_n_out,
  output logic                  reset_oe,
  // rail fault open-drain outputs
  output logic                  rail5_fault_n,
  output logic                  rail5_fault_oe,
  output logic                  rail6_fault_n,
  output logic                  rail6_fault_oe,
  output logic                  rail7_fault_n,
  output logic                  rail7_fault_oe,
  output logic                  rail8_fault_n,
  output logic                  rail8_fault_oe
);

  // sized copies of the duration parameters
  localparam logic [CNT_W-1:0] STARTUP_LIM = CNT_W'(STARTUP_TICKS);
  localparam logic [CNT_W-1:0] WDT_LIM     = CNT_W'(WDT_TICKS);
  localparam logic [CNT_W-1:0] RST_INT_LIM = CNT_W'(RST_INT_TICKS);
  localparam logic [CNT_W-1:0] SRT_SCALE   = CNT_W'(SRT_US_PER_NF);

  // idle levels of the pins while in reset: kick and open low, others high
  localparam logic [SYNC_W-1:0] SYNC_INIT  = 9'h1fc;

  // synchronised pin levels
  logic [SYNC_W-1:0] pin_raw;          // pins as they arrive
  logic [SYNC_W-1:0] pin_s;            // after two flops
  logic              kick_s;           // kick level
  logic              open_s;           // open-state detector
  logic              mr_n_s;           // manual reset, low active
  logic              margin_n_s;       // margin disable, low active
  logic              srt_vcc_s;        // timeout pin tied to supply
  logic [3:0]        rail_ok_s;        // rails 5..8 above threshold
  logic              rpin_s;           // reset wire level read back

  // time base
  logic              tick;             // one pulse per microsecond

  // watchdog
  wrs_wd_state_type  wd_state_reg;     // watchdog state
  wrs_wd_state_type  wd_state_next;
  logic [CNT_W-1:0]  wd_cnt_reg;       // elapsed ticks since last clear
  logic              kick_prev_reg;    // kick level one cycle ago
  logic              kick_edge;        // rising or falling edge
  logic              wd_clear;         // any cause to clear the timer
  logic [CNT_W-1:0]  wd_limit;         // active timeout
  logic              wd_fire;          // timeout reached this tick

  // reset generator
  wrs_rst_state_type rst_state_reg;    // reset output state
  wrs_rst_state_type rst_state_next;
  logic [CNT_W-1:0]  rst_cnt_reg;      // ticks spent stretching
  logic [CNT_W-1:0]  rst_limit;        // selected reset timeout
  logic              rst_cause;        // level cause for reset
  logic              rst_active;       // internal reset asserted

  // output register copies
  logic              reset_n_reg;      // registered reset level
  logic [3:0]        fault_n_reg;      // registered fault levels

  // gather the outside levels into one vector
  assign pin_raw = {rail8_sense, rail7_sense, rail6_sense, rail5_sense,
                    timeout_set_pin, margin_n, manual_reset_n,
                    kick_open, watchdog_kick_in};

  // every pin passes two flops before logic reads it
  wrs_sync2 #(
    .W    (SYNC_W),
    .INIT (SYNC_INIT)
  ) u_pin_sync (                                                   // [R14]
    .clk      (clk),
    .rstn     (rstn),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // reset wire read back, idle high
  wrs_sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_rpin_sync (                                                  // [R14]
    .clk      (clk),
    .rstn     (rstn),
    .async_in (reset_pin_in),
    .sync_out (rpin_s)
  );

  // name the synchronised bits
  assign kick_s     = pin_s[PIN_KICK];
  assign open_s     = pin_s[PIN_OPEN];
  assign mr_n_s     = pin_s[PIN_MR_N];
  assign margin_n_s = pin_s[PIN_MARGIN_N];
  assign srt_vcc_s  = pin_s[PIN_SRT_VCC];
  assign rail_ok_s  = pin_s[PIN_RAIL5 +: 4];

  // microsecond enable for all long counts
  wrs_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (                                                       // [R13]
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  // kick edge detector on the synchronised level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_s;
    end
  end

  // either direction counts as a kick
  assign kick_edge = kick_s ^ kick_prev_reg;                       // [R2]

  // timer clears on an edge or while reset is low from any source
  assign wd_clear = kick_edge                                      // [R2]
                  | rst_active | ~rpin_s;                          // [R3]

  // grace period before the first kick, normal timeout afterwards
  always_comb begin
    if (wd_state_reg == WRS_WD_STARTUP) begin
      wd_limit = STARTUP_LIM;                                      // [R4]
    end else begin
      wd_limit = WDT_LIM;
    end
  end

  // expiry of a steady kick level
  assign wd_fire = (wd_state_reg != WRS_WD_OFF) && !wd_clear &&
                   tick && (wd_cnt_reg >= wd_limit - 1'b1);        // [R1]

  // watchdog state transitions
  always_comb begin
    wd_state_next = wd_state_reg;
    case (wd_state_reg)
      WRS_WD_OFF: begin
        // pin connected again: start with the grace period
        if (!open_s) begin
          wd_state_next = WRS_WD_STARTUP;
        end
      end
      WRS_WD_STARTUP: begin
        // first kick ends the grace period
        if (open_s) begin
          wd_state_next = WRS_WD_OFF;                              // [R5]
        end else if (kick_edge && !rst_active) begin
          wd_state_next = WRS_WD_RUN;                              // [R4]
        end
      end
      WRS_WD_RUN: begin
        // a reset restarts the grace period
        if (open_s) begin
          wd_state_next = WRS_WD_OFF;                              // [R5]
        end else if (rst_active || wd_fire) begin
          wd_state_next = WRS_WD_STARTUP;                          // [R4]
        end
      end
      default: begin
        wd_state_next = WRS_WD_OFF;
      end
    endcase
  end

  // watchdog state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wd_state_reg <= WRS_WD_STARTUP;                              // [R4]
    end else begin
      wd_state_reg <= wd_state_next;
    end
  end

  // watchdog tick counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wd_cnt_reg <= '0;
    end else if (wd_state_reg == WRS_WD_OFF || open_s) begin
      wd_cnt_reg <= '0;                                            // [R5]
    end else if (wd_clear || wd_fire) begin
      wd_cnt_reg <= '0;                                            // [R1] [R2] [R3]
    end else if (tick) begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;                             // [R13]
    end
  end

  // any rail low or manual reset low is a level cause
  assign rst_cause = ~mr_n_s                                       // [R7]
                   | ~(&rail_ok_s);                                // [R11]

  // timeout choice: internal when tied to supply, else capacitor
  always_comb begin
    if (srt_vcc_s) begin
      rst_limit = RST_INT_LIM;                                     // [R10]
    end else begin
      rst_limit = CNT_W'(srt_cap_nf) * SRT_SCALE;                  // [R9]
    end
  end

  // reset output state transitions
  always_comb begin
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      WRS_RST_HOLD: begin
        // hold while a cause stands, then stretch
        if (!rst_cause) begin
          rst_state_next = WRS_RST_TIMEOUT;                        // [R8] [R11]
        end
      end
      WRS_RST_TIMEOUT: begin
        // a new cause restarts the stretch; done after full timeout
        if (rst_cause) begin
          rst_state_next = WRS_RST_HOLD;                           // [R7]
        end else if (tick && (rst_cnt_reg >= rst_limit - 1'b1)) begin
          rst_state_next = WRS_RST_RUN;                            // [R8]
        end else if (rst_limit == '0) begin
          rst_state_next = WRS_RST_RUN;                            // zero capacitance
        end
      end
      WRS_RST_RUN: begin
        // level cause first, watchdog expiry gives one timeout
        if (rst_cause) begin
          rst_state_next = WRS_RST_HOLD;                           // [R7] [R11]
        end else if (wd_fire) begin
          rst_state_next = WRS_RST_TIMEOUT;                        // [R1]
        end
      end
      default: begin
        rst_state_next = WRS_RST_HOLD;
      end
    endcase
  end

  // reset state register, power-up starts asserted
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_state_reg <= WRS_RST_HOLD;
    end else begin
      rst_state_reg <= rst_state_next;
    end
  end

  // stretch counter runs only while stretching
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_cnt_reg <= '0;
    end else if (rst_state_reg != WRS_RST_TIMEOUT || rst_cause) begin
      rst_cnt_reg <= '0;                                           // [R8]
    end else if (tick) begin
      rst_cnt_reg <= rst_cnt_reg + 1'b1;                           // [R13]
    end
  end

  // internal reset is asserted in every state but run
  assign rst_active = (rst_state_reg != WRS_RST_RUN);

  // registered output levels, margin low releases everything
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reset_n_reg <= 1'b0;
      fault_n_reg <= 4'h0;
    end else if (!margin_n_s) begin
      reset_n_reg <= 1'b1;                                         // [R12]
      fault_n_reg <= 4'hf;                                         // [R12]
    end else begin
      reset_n_reg <= ~rst_active;                                  // [R7] [R8]
      fault_n_reg <= rail_ok_s;                                    // [R6]
    end
  end

  // open-drain drive: enable pulls low, else released
  assign reset_n_out    = reset_n_reg;
  assign reset_oe       = ~reset_n_reg;
  assign rail5_fault_n  = fault_n_reg[0];
  assign rail5_fault_oe = ~fault_n_reg[0];
  assign rail6_fault_n  = fault_n_reg[1];
  assign rail6_fault_oe = ~fault_n_reg[1];
  assign rail7_fault_n  = fault_n_reg[2];
  assign rail7_fault_oe = ~fault_n_reg[2];
  assign rail8_fault_n  = fault_n_reg[3];
  assign rail8_fault_oe = ~fault_n_reg[3];

endmodule : wrs_supervisor

// file: verif/wrs_supervisor_assertions.sv
/*
  port checker for the watchdog and reset supervisor.
  assumes the reset wire read-back is the resolved open-drain level.
*/
`timescale 1ns/1ps
module wrs_supervisor_checker #(
  parameter int unsigned STARTUP_TICKS = 200,   // startup grace, ticks
  parameter int unsigned WDT_TICKS     = 50,    // watchdog timeout, ticks
  parameter int unsigned RST_INT_TICKS = 30     // reset timeout, ticks
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins in
  input wire logic watchdog_kick_in,
  input wire logic kick_open,
  input wire logic manual_reset_n,
  input wire logic margin_n,
  input wire logic timeout_set_pin,
  input wire logic rail5_sense,
  input wire logic rail6_sense,
  input wire logic rail7_sense,
  input wire logic rail8_sense,
  input wire logic reset_pin_in,
  // pins out
  input wire logic reset_n_out,
  input wire logic reset_oe,
  input wire logic rail5_fault_n,
  input wire logic rail5_fault_oe,
  input wire logic rail6_fault_n,
  input wire logic rail7_fault_n,
  input wire logic rail8_fault_n
);
  localparam int QUIET_MIN = (int'(RST_INT_TICKS) - 1) * 10;   // one tick slack
  localparam int WD_MIN    = (int'(WDT_TICKS) - 1) * 10;       // earliest bite
  localparam int WD_MAX    = (int'(STARTUP_TICKS) + 3) * 10;   // latest bite
  logic [3:0]  rails;       // rail levels 8..5
  logic [3:0]  faults;      // fault levels 8..5
  logic [31:0] quiet_cnt;   // cycles without a reset cause
  logic [31:0] still_cnt;   // cycles without a kick edge
  logic [31:0] marg_cnt;    // cycles with margin high
  logic        kick_d;      // kick pin one cycle back
  assign rails  = {rail8_sense, rail7_sense, rail6_sense, rail5_sense};
  assign faults = {rail8_fault_n, rail7_fault_n, rail6_fault_n, rail5_fault_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // span counters behind the timing checks
  always_ff @(posedge clk) begin
    kick_d    <= watchdog_kick_in;
    quiet_cnt <= (!rstn || !manual_reset_n || !(&rails)) ? '0 : quiet_cnt + 1;
    still_cnt <= (!rstn || !reset_pin_in || kick_open || kick_d != watchdog_kick_in)
                 ? '0 : still_cnt + 1;
    marg_cnt  <= (!rstn || !margin_n) ? '0 : marg_cnt + 1;
  end
  property p_follow;
    margin_n [*3] |=> faults == $past(rails, 3);
  endproperty
  a_follow: assert property (p_follow) else $error("fault level lags rail");
  property p_oe;
    (reset_oe == !reset_n_out) && (rail5_fault_oe == !rail5_fault_n);
  endproperty
  a_oe: assert property (p_oe) else $error("enable not inverse of level");
  property p_margin;
    (!margin_n) [*3] |=> reset_n_out && (&faults);
  endproperty
  a_margin: assert property (p_margin) else $error("output low under margin");
  property p_mr;
    (!manual_reset_n && margin_n) [*4] |=> !reset_n_out;
  endproperty
  a_mr: assert property (p_mr) else $error("manual reset not held");
  property p_rail;
    (!rail6_sense && margin_n) [*4] |=> !reset_n_out;
  endproperty
  a_rail: assert property (p_rail) else $error("low rail gives no reset");
  property p_stretch;
    $rose(reset_n_out) && timeout_set_pin && marg_cnt > 8 |-> quiet_cnt >= QUIET_MIN;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset released early");
  property p_wd_fire;
    (still_cnt == WD_MAX) && (marg_cnt > still_cnt) |-> !reset_n_out;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog never bit");
  property p_wd_early;
    $fell(reset_n_out) && marg_cnt > 8 && quiet_cnt > 8 |-> still_cnt >= WD_MIN;
  endproperty
  a_wd_early: assert property (p_wd_early) else $error("watchdog bit early");
  c_wd: cover property ($fell(reset_n_out) && quiet_cnt > 8);
  c_stretch: cover property ($rose(reset_n_out) && quiet_cnt > 100);
  c_margin: cover property ($rose(reset_n_out) && !margin_n);
endmodule : wrs_supervisor_checker

bind wrs_supervisor wrs_supervisor_checker #(
  .STARTUP_TICKS(STARTUP_TICKS), .WDT_TICKS(WDT_TICKS), .RST_INT_TICKS(RST_INT_TICKS)
) u_wrs_supervisor_checker (
  .clk(clk), .rstn(rstn), .watchdog_kick_in(watchdog_kick_in), .kick_open(kick_open),
  .manual_reset_n(manual_reset_n), .margin_n(margin_n), .timeout_set_pin(timeout_set_pin),
  .rail5_sense(rail5_sense), .rail6_sense(rail6_sense), .rail7_sense(rail7_sense),
  .rail8_sense(rail8_sense), .reset_pin_in(reset_pin_in), .reset_n_out(reset_n_out),
  .reset_oe(reset_oe), .rail5_fault_n(rail5_fault_n), .rail5_fault_oe(rail5_fault_oe),
  .rail6_fault_n(rail6_fault_n), .rail7_fault_n(rail7_fault_n), .rail8_fault_n(rail8_fault_n)
);

// file: verif/wrs_host_model.sv
/*
  host processor model: kicks the watchdog and holds the manual reset.
  assumes negedge driving and a pulled-up reset wire.
*/
`timescale 1ns/1ps
module wrs_host_model (
  // clock and reset wire
  input  wire logic        clk,
  input  wire logic        reset_line,
  // bench controls
  input  wire logic        run,
  input  wire logic        float_req,
  input  wire logic        mr_req,
  input  wire logic [15:0] period,
  // pins
  output logic             watchdog_kick_in,
  output logic             kick_open,
  output logic             manual_reset_n
);
  int cnt;   // cycles since last kick
  // kick every period cycles, paused while the host is held in reset
  initial begin
    watchdog_kick_in = 1'b0;
    cnt              = 0;
    forever begin
      @(negedge clk);
      if (float_req) begin
        cnt = 0;   // open pin: steady level, so only the detector can stop a bite
      end else if (!run || !reset_line) begin
        cnt = 0;
      end else if (cnt >= int'(period) - 1) begin
        watchdog_kick_in = ~watchdog_kick_in;
        cnt              = 0;
      end else begin
        cnt = cnt + 1;
      end
    end
  end
  // open detector and button level
  assign kick_open      = float_req;
  assign manual_reset_n = !mr_req;
endmodule : wrs_host_model

// file: verif/tb_top.sv
/*
  self-checking bench for the watchdog and reset supervisor.
  assumes shortened tick counts and a pulled-up reset wire.
*/
`timescale 1ns/1ps
module tb_top;
  import wrs_pkg::*;
  localparam int TC = 10;   // cycles per tick
  localparam int ST = 200;  // startup ticks
  localparam int WD = 50;   // watchdog ticks
  localparam int RT = 30;   // reset timeout ticks
  logic             clk, rstn, margin_n, timeout_set_pin, run, float_req, mr_req;
  logic [CAP_W-1:0] srt_cap_nf;
  logic [3:0]       rails;     // rail sense 8..5
  logic [15:0]      period;    // kick spacing
  logic             watchdog_kick_in, kick_open, manual_reset_n, reset_n_out, reset_oe;
  logic [3:0]       fault_n, fault_oe;
  wire              reset_line = reset_oe ? 1'b0 : 1'b1;   // pulled-up wire
  int               miscompares, samples_checked, n;
  // clock
  initial clk = 1'b0;
  always #50 clk = ~clk;
  wrs_supervisor #(.STARTUP_TICKS(ST), .WDT_TICKS(WD), .RST_INT_TICKS(RT)) u_wrs_supervisor (
    .clk(clk), .rstn(rstn), .watchdog_kick_in(watchdog_kick_in), .kick_open(kick_open),
    .manual_reset_n(manual_reset_n), .margin_n(margin_n), .timeout_set_pin(timeout_set_pin),
    .srt_cap_nf(srt_cap_nf), .rail5_sense(rails[0]), .rail6_sense(rails[1]),
    .rail7_sense(rails[2]), .rail8_sense(rails[3]), .reset_pin_in(reset_line),
    .reset_n_out(reset_n_out), .reset_oe(reset_oe),
    .rail5_fault_n(fault_n[0]), .rail5_fault_oe(fault_oe[0]),
    .rail6_fault_n(fault_n[1]), .rail6_fault_oe(fault_oe[1]),
    .rail7_fault_n(fault_n[2]), .rail7_fault_oe(fault_oe[2]),
    .rail8_fault_n(fault_n[3]), .rail8_fault_oe(fault_oe[3]));
  wrs_host_model u_wrs_host_model (
    .clk(clk), .reset_line(reset_line), .run(run), .float_req(float_req), .mr_req(mr_req),
    .period(period), .watchdog_kick_in(watchdog_kick_in), .kick_open(kick_open),
    .manual_reset_n(manual_reset_n));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic check_vec(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_vec
  task automatic check_span(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error at %0t: span %0h expected %0h to %0h", $time, got, lo, hi);
    end
  endtask : check_span
  // cycles until the reset wire reaches a level, bounded
  task automatic wait_lvl(input logic lvl, input int lim, output int k);
    k = 0;
    while (reset_line !== lvl && k < lim) begin
      cyc(1);
      k++;
    end
  endtask : wait_lvl
  task automatic t_rails;
    for (int i = 0; i < 4; i++) begin
      rails[i] = 1'b0;
      cyc(5);
      check_vec(fault_n, ~(4'h1 << i));
      check_vec(fault_oe, 4'h1 << i);
      check_vec({3'h0, reset_line}, 4'h0);
      rails[i] = 1'b1;
      cyc(5);
      check_vec(fault_n, 4'hf);
      wait_lvl(1'b1, 2000, n);
      check_span(n, RT * TC - 2 * TC, RT * TC + 3 * TC);
    end
  endtask : t_rails
  task automatic t_mr;
    mr_req = 1'b1;
    cyc(5);
    check_vec({3'h0, reset_line}, 4'h0);
    cyc(40);
    mr_req = 1'b0;
    cyc(150);
    check_vec({3'h0, reset_line}, 4'h0);
    mr_req = 1'b1;
    cyc(5);
    mr_req = 1'b0;
    wait_lvl(1'b1, 2000, n);
    check_span(n, RT * TC - TC, RT * TC + 3 * TC);
  endtask : t_mr
  task automatic t_margin;
    rails[0] = 1'b0;
    mr_req   = 1'b1;
    cyc(5);
    margin_n = 1'b0;
    cyc(5);
    check_vec(fault_n, 4'hf);
    check_vec(fault_oe, 4'h0);
    check_vec({3'h0, reset_line}, 4'h1);
    margin_n = 1'b1;
    cyc(5);
    check_vec(fault_n, 4'he);
    check_vec({3'h0, reset_line}, 4'h0);
    rails[0] = 1'b1;
    mr_req   = 1'b0;
    wait_lvl(1'b1, 2000, n);
    check_span(n, RT * TC - TC, RT * TC + 3 * TC);
  endtask : t_margin
  task automatic t_kick_open;
    run       = 1'b0;
    float_req = 1'b1;
    repeat (25) begin
      cyc(100);
      check_vec({3'h0, reset_line}, 4'h1);
    end
    float_req = 1'b0;
    run       = 1'b1;
    cyc(100);
  endtask : t_kick_open
  task automatic t_watchdog;
    run = 1'b0;
    cyc(WD * TC - 3 * TC);
    check_vec({3'h0, reset_line}, 4'h1);
    wait_lvl(1'b0, 60, n);
    check_span(n, 0, 59);
    wait_lvl(1'b1, 2000, n);
    check_span(n, RT * TC - 2 * TC, RT * TC + 3 * TC);
    cyc(ST * TC - 2 * TC);
    check_vec({3'h0, reset_line}, 4'h1);
    wait_lvl(1'b0, 60, n);
    check_span(n, 0, 59);
    wait_lvl(1'b1, 2000, n);
    run = 1'b1;
  endtask : t_watchdog
  task automatic t_cap;
    timeout_set_pin = 1'b0;
    srt_cap_nf      = 16'h0001;
    mr_req          = 1'b1;
    cyc(10);
    mr_req = 1'b0;
    wait_lvl(1'b1, 22000, n);
    // 2.06 Mohm times 1 nF is 2060 us
    check_span(n, 2060 * TC - TC, 2060 * TC + 3 * TC);
    timeout_set_pin = 1'b1;
  endtask : t_cap
  task automatic finish_test;
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // hang guard, well beyond the expected run
  initial begin
    #6000000;
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    rstn            = 1'b0;
    margin_n        = 1'b1;
    timeout_set_pin = 1'b1;
    srt_cap_nf      = '0;
    run             = 1'b1;
    float_req       = 1'b0;
    mr_req          = 1'b0;
    rails           = 4'hf;
    period          = 16'h0014;
    miscompares     = 0;
    samples_checked = 0;
    cyc(10);
    rstn = 1'b1;
    wait_lvl(1'b1, 2000, n);
    check_span(n, RT * TC - TC, RT * TC + 3 * TC);
    t_rails();
    t_mr();
    t_margin();
    t_kick_open();
    t_watchdog();
    t_cap();
    finish_test();
  end
endmodule : tb_top
